// [hdl/lxt_line_exposure_timing.sv]
// Line exposure timing controller with a classic Wishbone register slave.
// Assumes trigger inputs synchronous to sys_clk and a 20 MHz sys_clk.
`timescale 1ns/1ps
`include "lxt_params.svh"

// Overview of operation
// - Hold mode 2..8, reset to mode 7.
// - Mode 2 internal sync, programmable rate and exposure.
// - Mode 3 external sync, maximum exposure, no control.
// - Mode 3 trigger spacing sets line, fall starts.
// - Mode 4 rise starts exposure, fall starts readout.
// - Mode 5 trigger fall readout, reset rise exposes.
// - Mode 6 external rate, fixed internal exposure.
// - Mode 7 internal rate, maximum exposure, no control.
// - Mode 8 fastest line for programmed exposure.
// - Mode 2 new rate trims exposure to fit.
// - Mode 2 long exposure stretches the line.
// - Line rate accepted only in modes 2, 7.
// - Line rate limits follow sensor and taps.
// - Bad line rate refused, flagged, unchanged.
// - Exposure accepted only in modes 2, 6, 8.
// - Exposure 3..3300 us, capped by line rate in mode 6.
// - Report largest exposure for programmed rate.
// - Report selected exposure mode on read.
// - Tap count follows the data mode setting.
module lxt_line_exposure_timing (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic             ack_o,
   output logic [31:0]      dat_o,
   input  wire logic        externalLineTrigger,
   input  wire logic        pixelResetInput,
   output logic             exposureOn,
   output logic             chargeClearPulse,
   output logic             readoutStart,
   output logic             exposureControlOn
);

   lxt_pkg::lxt_state_s s_reg;  // Registered state.
   lxt_pkg::lxt_state_s s_next; // Next state.

   logic        usTick;    // One-cycle microsecond enable.
   logic        busTake;   // A new bus request is taken this cycle.
   logic        wrTake;    // A full-word write is taken this cycle.
   logic [12:0] effExp;    // Exposure length of an internal line.
   logic [12:0] expStart;  // Line position where exposure begins.
   logic [12:0] nextCnt;   // Next internal line position.
   logic        lineWrap;  // Internal line ends at this tick.
   logic        trigRise;  // Rising edge of the line trigger.
   logic        trigFall;  // Falling edge of the line trigger.
   logic        prstRise;  // Rising edge of the pixel reset input.
   logic [2:0]  errSet;    // Error events of this cycle.
   logic [2:0]  errClr;    // Error flags cleared by software.
   logic [12:0] newLine;   // Line period of a requested rate.
   logic [12:0] newMax;    // Largest exposure of a requested rate.

   // Line period in microseconds for a rate; zero is treated as the slowest.
   function automatic logic [12:0] periodUs(input logic [16:0] r);
      logic [31:0] q;
      q = (r == 17'h00000) ? `LXT_US_PER_S : `LXT_US_PER_S / {15'h0000, r};
      return q[12:0];
   endfunction

   // Largest exposure that fits a line at this rate.
   function automatic logic [12:0] maxExpUs(input logic [16:0] r);
      return periodUs(r) - `LXT_XFER_US - `LXT_PRST_US;
   endfunction

   // Upper rate limit for the sensor length and the tap count.
   function automatic logic [16:0] rateMax(input logic long2k, input logic dualTap);
      if (long2k) begin
         return dualTap ? `LXT_RATE_STD : `LXT_RATE_SLOW;
      end
      return dualTap ? `LXT_RATE_FAST : `LXT_RATE_STD;
   endfunction

   // Modes that run with exposure control enabled.
   function automatic logic ecMode(input logic [3:0] m);
      return (m != `LXT_MODE_EXTMAX) && (m != `LXT_MODE_INTMAX);
   endfunction

   // Bus handshake: one request per ack, ack dropped the cycle after.
   assign busTake = cyc_i & stb_i & ~s_reg.ack;
   // Partial writes are ignored so no register ever holds a torn value.
   assign wrTake  = busTake & we_i & (&sel_i);

   // Tick and edge detection used by the timing engine.
   assign usTick   = (s_reg.usDiv == 5'(`LXT_US_CYC - 1));
   assign trigRise = externalLineTrigger & ~s_reg.trigPrev;
   assign trigFall = ~externalLineTrigger & s_reg.trigPrev;
   assign prstRise = pixelResetInput & ~s_reg.prstPrev;

   // Internal line geometry; mode 7 takes all the time left in the line.
   always_comb begin
      effExp = (s_reg.mode == `LXT_MODE_INTMAX) ?
               s_reg.lineUs - `LXT_XFER_US - `LXT_PRST_US :
               {1'b0, s_reg.expUs};
      expStart = s_reg.lineUs - effExp;
      lineWrap = (s_reg.lineCnt >= s_reg.lineUs - 13'h0001);
      nextCnt  = lineWrap ? 13'h0000 : s_reg.lineCnt + 13'h0001;
   end

   // Period and exposure ceiling for a rate being written.
   assign newLine = periodUs(dat_i[16:0]);
   assign newMax  = maxExpUs(dat_i[16:0]);

   // Next-state logic: bus slave, command checks and the timing engine.
   always_comb begin
      s_next              = s_reg;
      s_next.readoutStart = 1'b0;
      s_next.ack          = 1'b0;
      s_next.dat          = 32'h00000000;
      s_next.trigPrev     = externalLineTrigger;
      s_next.prstPrev     = pixelResetInput;
      errSet              = 3'h0;
      errClr              = 3'h0;
      s_next.usDiv        = usTick ? 5'h00 : s_reg.usDiv + 5'h01;

      // Timing engine; each mode decides when to clear, expose and read out.
      case (s_reg.mode)
         `LXT_MODE_EXTMAX: begin
            // The trigger fall closes one line and opens the next.
            if (trigFall) begin
               s_next.readoutStart = 1'b1;
               s_next.phase        = lxt_pkg::PH_CLEAR;
               s_next.phCnt        = 13'h0000;
            end else if (s_reg.phase == lxt_pkg::PH_CLEAR && usTick) begin
               if (s_reg.phCnt >= `LXT_PRST_US - 13'h0001) begin
                  s_next.phase = lxt_pkg::PH_EXPOSE;
               end else begin
                  s_next.phCnt = s_reg.phCnt + 13'h0001;
               end
            end
         end
         `LXT_MODE_SMART: begin
            // Trigger high time is the exposure; the clear is one cycle.
            if (trigRise) begin
               s_next.phase = lxt_pkg::PH_CLEAR;
            end else if (trigFall) begin
               s_next.readoutStart = 1'b1;
               s_next.phase        = lxt_pkg::PH_IDLE;
            end else if (s_reg.phase == lxt_pkg::PH_CLEAR) begin
               s_next.phase = lxt_pkg::PH_EXPOSE;
            end
         end
         `LXT_MODE_EXTRST: begin
            // Pixel reset is external here, so no charge clear is made.
            if (trigFall) begin
               s_next.readoutStart = 1'b1;
               s_next.phase        = lxt_pkg::PH_IDLE;
            end else if (prstRise) begin
               s_next.phase = lxt_pkg::PH_EXPOSE;
            end
         end
         `LXT_MODE_EXTFIX: begin
            // A trigger that comes before the exposure ends cuts it short.
            if (trigFall) begin
               s_next.readoutStart = 1'b1;
               s_next.phase        = lxt_pkg::PH_CLEAR;
               s_next.phCnt        = 13'h0000;
            end else if (usTick && s_reg.phase != lxt_pkg::PH_IDLE) begin
               if (s_reg.phase == lxt_pkg::PH_CLEAR &&
                   s_reg.phCnt >= `LXT_PRST_US - 13'h0001) begin
                  s_next.phase = lxt_pkg::PH_EXPOSE;
                  s_next.phCnt = 13'h0000;
               end else if (s_reg.phase == lxt_pkg::PH_EXPOSE &&
                            s_reg.phCnt >= {1'b0, s_reg.expUs} - 13'h0001) begin
                  s_next.phase = lxt_pkg::PH_IDLE;
               end else begin
                  s_next.phCnt = s_reg.phCnt + 13'h0001;
               end
            end
         end
         default: begin
            // Modes 2, 7 and 8 run from the internal line counter.
            if (usTick) begin
               s_next.lineCnt      = nextCnt;
               s_next.readoutStart = lineWrap;
               if (nextCnt >= expStart) begin
                  s_next.phase = lxt_pkg::PH_EXPOSE;
               end else if (nextCnt >= expStart - `LXT_PRST_US) begin
                  s_next.phase = lxt_pkg::PH_CLEAR;
               end else begin
                  s_next.phase = lxt_pkg::PH_IDLE;
               end
            end
         end
      endcase

      // Register reads return the value held before this cycle's write.
      if (busTake && !we_i) begin
         case (adr_i)
            `LXT_OFF_MODE:   s_next.dat = {28'h0000000, s_reg.mode};
            `LXT_OFF_RATE:   s_next.dat = {15'h0000, s_reg.rate};
            `LXT_OFF_EXP:    s_next.dat = {20'h00000, s_reg.expUs};
            `LXT_OFF_CFG:    s_next.dat = {29'h00000000, s_reg.dataMode, s_reg.sensor2k};
            `LXT_OFF_STAT:   s_next.dat = {26'h0000000, s_reg.phase, s_reg.ecOn, s_reg.err};
            `LXT_OFF_MAXEXP: s_next.dat = {19'h00000, maxExpUs(s_reg.rate)};
            `LXT_OFF_LINE:   s_next.dat = {19'h00000, s_reg.lineUs};
            default:         s_next.dat = 32'h00000000;
         endcase
      end
      if (busTake) begin
         s_next.ack = 1'b1;
      end

      // Register writes with their range checks and side effects.
      if (wrTake) begin
         case (adr_i)
            `LXT_OFF_MODE: begin
               if (dat_i[31:4] == 28'h0000000 && dat_i[3:0] >= `LXT_MODE_PROG &&
                   dat_i[3:0] <= `LXT_MODE_MAXLR) begin
                  s_next.mode    = dat_i[3:0];
                  s_next.phase   = lxt_pkg::PH_IDLE;
                  s_next.lineCnt = 13'h0000;
                  s_next.phCnt   = 13'h0000;
                  // Mode 8 and a long mode 2 exposure set the line from the exposure.
                  if (dat_i[3:0] == `LXT_MODE_MAXLR ||
                      (dat_i[3:0] == `LXT_MODE_PROG &&
                       {1'b0, s_reg.expUs} > maxExpUs(s_reg.rate))) begin
                     s_next.lineUs = {1'b0, s_reg.expUs} + `LXT_XFER_US;
                  end else begin
                     s_next.lineUs = periodUs(s_reg.rate);
                  end
               end else begin
                  errSet[`LXT_ERR_MODE] = 1'b1;
               end
            end
            `LXT_OFF_RATE: begin
               if ((s_reg.mode == `LXT_MODE_PROG || s_reg.mode == `LXT_MODE_INTMAX) &&
                   dat_i[31:17] == 15'h0000 && dat_i[16:0] >= `LXT_RATE_MIN &&
                   dat_i[16:0] <= rateMax(s_reg.sensor2k,
                                          s_reg.dataMode[1])) begin
                  s_next.rate    = dat_i[16:0];
                  s_next.lineUs  = newLine;
                  s_next.lineCnt = 13'h0000;
                  if (s_reg.mode == `LXT_MODE_PROG && {1'b0, s_reg.expUs} > newMax) begin
                     s_next.expUs = newMax[11:0];
                  end
               end else begin
                  errSet[`LXT_ERR_RATE] = 1'b1;
               end
            end
            `LXT_OFF_EXP: begin
               if ((s_reg.mode == `LXT_MODE_PROG || s_reg.mode == `LXT_MODE_EXTFIX ||
                    s_reg.mode == `LXT_MODE_MAXLR) &&
                   dat_i[31:12] == 20'h00000 && dat_i[11:0] >= `LXT_EXP_MIN &&
                   dat_i[11:0] <= `LXT_EXP_MAX &&
                   (s_reg.mode != `LXT_MODE_EXTFIX ||
                    {1'b0, dat_i[11:0]} <= maxExpUs(s_reg.rate))) begin
                  s_next.expUs = dat_i[11:0];
                  if (s_reg.mode == `LXT_MODE_MAXLR ||
                      {1'b0, dat_i[11:0]} > maxExpUs(s_reg.rate)) begin
                     s_next.lineUs  = {1'b0, dat_i[11:0]} + `LXT_XFER_US;
                     s_next.lineCnt = 13'h0000;
                  end else begin
                     s_next.lineUs = periodUs(s_reg.rate);
                  end
               end else begin
                  errSet[`LXT_ERR_EXP] = 1'b1;
               end
            end
            `LXT_OFF_CFG: begin
               s_next.sensor2k = dat_i[`LXT_CFG_2K];
               s_next.dataMode = dat_i[`LXT_CFG_DM_LO +: 2];
            end
            `LXT_OFF_STAT: begin
               errClr = dat_i[2:0];
            end
            default: begin
               // Writes to read-only or unmapped words are acknowledged and dropped.
            end
         endcase
      end

      // A new error beats a simultaneous software clear.
      s_next.err = (s_reg.err & ~errClr) | errSet;

      // Outputs are registered copies of the next phase and mode.
      s_next.ecOn        = ecMode(s_next.mode);
      s_next.exposureOn  = (s_next.phase == lxt_pkg::PH_EXPOSE);
      s_next.chargeClear = (s_next.phase == lxt_pkg::PH_CLEAR);
   end

   // State register; reset loads mode 7 and the default line and exposure.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_reg        <= '0;
         s_reg.mode   <= `LXT_MODE_RST;
         s_reg.rate   <= `LXT_RATE_RST;
         s_reg.lineUs <= `LXT_LINE_RST;
         s_reg.expUs  <= `LXT_EXP_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // All outputs come straight from the state register.
   assign ack_o             = s_reg.ack;
   assign dat_o             = s_reg.dat;
   assign exposureOn        = s_reg.exposureOn;
   assign chargeClearPulse  = s_reg.chargeClear;
   assign readoutStart      = s_reg.readoutStart;
   assign exposureControlOn = s_reg.ecOn;

endmodule // lxt_line_exposure_timing

// [inc/lxt_params.svh]
// Constants for the line exposure timing controller: register offsets,
// field positions, reset values, limits and timing figures.
// Assumes a 20 MHz system clock and a 32-bit classic Wishbone register bus.
`ifndef LXT_PARAMS_SVH
`define LXT_PARAMS_SVH

// Clock rate in hertz (20 MHz) and microseconds per second.
`define LXT_CLK_HZ      32'h01312d00
`define LXT_US_PER_S    32'h000f4240
// Cycles in one microsecond tick, derived from the clock rate.
`define LXT_US_CYC      (`LXT_CLK_HZ / `LXT_US_PER_S)

// Line transfer time and pixel reset time, in microseconds.
`define LXT_XFER_US     13'h0005
`define LXT_PRST_US     13'h0002

// Exposure mode codes.
`define LXT_MODE_PROG   4'h2
`define LXT_MODE_EXTMAX 4'h3
`define LXT_MODE_SMART  4'h4
`define LXT_MODE_EXTRST 4'h5
`define LXT_MODE_EXTFIX 4'h6
`define LXT_MODE_INTMAX 4'h7
`define LXT_MODE_MAXLR  4'h8
`define LXT_MODE_RST    `LXT_MODE_INTMAX

// Line rate limits in hertz (300, 36000, 68000, 18500).
`define LXT_RATE_MIN    17'h0012c
`define LXT_RATE_STD    17'h08ca0
`define LXT_RATE_FAST   17'h109a0
`define LXT_RATE_SLOW   17'h04844
// Exposure limits in microseconds (3, 3300).
`define LXT_EXP_MIN     12'h003
`define LXT_EXP_MAX     12'hce4

// Reset values: 10000 Hz, a 100 us line and a 50 us exposure.
`define LXT_RATE_RST    17'h02710
`define LXT_LINE_RST    13'h0064
`define LXT_EXP_RST     12'h032

// Register byte offsets.
`define LXT_OFF_MODE    8'h00
`define LXT_OFF_RATE    8'h04
`define LXT_OFF_EXP     8'h08
`define LXT_OFF_CFG     8'h0c
`define LXT_OFF_STAT    8'h10
`define LXT_OFF_MAXEXP  8'h14
`define LXT_OFF_LINE    8'h18

// Field positions in the configuration and status registers.
`define LXT_CFG_2K      0
`define LXT_CFG_DM_LO   1
`define LXT_ERR_RATE    0
`define LXT_ERR_EXP     1
`define LXT_ERR_MODE    2
`define LXT_STAT_ECON   3
`define LXT_STAT_PH_LO  4

`endif

// [inc/lxt_pkg.sv]
// Types for the line exposure timing controller.
// Assumes the constants of lxt_params.svh for widths of stored values.
package lxt_pkg;

   // Exposure phase of the current line, Gray coded along idle, clear, expose.
   typedef enum logic [1:0] {
      PH_IDLE   = 2'b00,
      PH_CLEAR  = 2'b01,
      PH_EXPOSE = 2'b11
   } lxt_phase_e;

   // Complete state of the controller, registered as one word.
   typedef struct packed {
      logic [3:0]  mode;         // Selected exposure mode.
      logic [16:0] rate;         // Programmed line rate in hertz.
      logic [12:0] lineUs;       // Active line period in microseconds.
      logic [11:0] expUs;        // Programmed exposure in microseconds.
      logic        sensor2k;     // Long sensor variant selected.
      logic [1:0]  dataMode;     // Bit depth and tap selection.
      logic [2:0]  err;          // Sticky command error flags.
      logic [4:0]  usDiv;        // Microsecond tick divider.
      logic [12:0] lineCnt;      // Position within an internal line.
      logic [12:0] phCnt;        // Time spent in the current phase.
      logic        trigPrev;     // Line trigger one cycle ago.
      logic        prstPrev;     // Pixel reset input one cycle ago.
      lxt_phase_e  phase;        // Current exposure phase.
      logic        exposureOn;   // Exposure output.
      logic        chargeClear;  // Charge clear output.
      logic        readoutStart; // Readout start pulse output.
      logic        ecOn;         // Exposure control active.
      logic        ack;          // Bus acknowledge.
      logic [31:0] dat;          // Bus read data.
   } lxt_state_s;

endpackage

// [test/lxt_line_exposure_timing_asserts.sv]
// Concurrent checks on the ports of the line exposure timing controller.
// Assumes one clock domain and a synchronous active high reset; bound to the top module below.
`timescale 1ns/1ps
module lxt_timing_asserts (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic        ack_o,
   input wire logic [31:0] dat_o,
   input wire logic        externalLineTrigger,
   input wire logic        pixelResetInput,
   input wire logic        exposureOn,
   input wire logic        chargeClearPulse,
   input wire logic        readoutStart,
   input wire logic        exposureControlOn
);
   logic [3:0] modeShadow_reg; // Mode last accepted over the bus.
   logic [2:0] modeAge_reg;    // Cycles since that write, saturating at seven.
   logic       modeWr;         // A valid full-word mode write is being taken this cycle.
   logic       settled;        // Long enough since a mode change for outputs to follow it.

   // The shadow moves on the taking edge, the same edge at which the controller switches mode.
   assign modeWr  = cyc_i && stb_i && we_i && !ack_o && adr_i == 8'h00 && sel_i == 4'hf
                    && dat_i >= 32'h2 && dat_i <= 32'h8;
   assign settled = modeAge_reg == 3'h7;

   // Shadow the mode so edge checks fire only in the mode they belong to.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         modeShadow_reg <= 4'h7;
         modeAge_reg    <= 3'h7;
      end else if (modeWr) begin
         modeShadow_reg <= dat_i[3:0];
         modeAge_reg    <= 3'h0;
      end else if (modeAge_reg != 3'h7) begin
         modeAge_reg <= modeAge_reg + 3'h1;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack stood longer than one cycle");
   a_ack_reply: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not answered");
   a_ec_mode: assert property (settled |-> exposureControlOn == (modeShadow_reg != 4'h3
      && modeShadow_reg != 4'h7)) else $error("exposure control flag wrong for mode");
   a_clear_apart: assert property (!(chargeClearPulse && exposureOn)) else $error("clear overlaps exposure");
   a_clear_then_exp: assert property (settled && (modeShadow_reg == 4'h3 || modeShadow_reg == 4'h4
      || modeShadow_reg == 4'h6) && $fell(chargeClearPulse) |-> exposureOn) else $error("clear did not lead on");
   a_ro_pulse: assert property (readoutStart |=> !readoutStart) else $error("readout pulse too long");
   a_m3_fall: assert property (settled && modeShadow_reg == 4'h3 && $fell(externalLineTrigger)
      |=> readoutStart ##[1:70] exposureOn) else $error("trigger fall did not start exposure");
   a_m4_rise: assert property (settled && modeShadow_reg == 4'h4 && $rose(externalLineTrigger)
      |=> chargeClearPulse ##1 (exposureOn && !chargeClearPulse)) else $error("rise did not expose");
   a_m4_fall: assert property (settled && modeShadow_reg == 4'h4 && $fell(externalLineTrigger)
      |=> readoutStart && !exposureOn) else $error("fall did not start readout");
   a_m5_prst: assert property (settled && modeShadow_reg == 4'h5 && $rose(pixelResetInput)
      |=> exposureOn) else $error("pixel reset rise did not expose");
   a_m5_fall: assert property (settled && modeShadow_reg == 4'h5 && $fell(externalLineTrigger)
      |=> readoutStart && !exposureOn) else $error("trigger fall did not end line");

   c_m4_rise: cover property (settled && modeShadow_reg == 4'h4 && $rose(externalLineTrigger));
   c_m5_prst: cover property (settled && modeShadow_reg == 4'h5 && $rose(pixelResetInput));
   c_readout: cover property (settled && readoutStart);
endmodule // lxt_timing_asserts

bind lxt_line_exposure_timing lxt_timing_asserts i_chk (.sys_clk, .rst, .cyc_i, .stb_i, .we_i, .adr_i,
   .sel_i, .dat_i, .ack_o, .dat_o, .externalLineTrigger, .pixelResetInput, .exposureOn, .chargeClearPulse,
   .readoutStart, .exposureControlOn);

// [test/lxt_line_exposure_timing_tb_top.sv]
// Self-checking bench: Wishbone register access plus the trigger source model.
// Assumes the controller, its checker and lxt_trig_src are compiled before this file.
`timescale 1ns/1ps
`define TB_CHK(a, e, m) begin checked++; if ((a) !== (e)) begin miscompares++; \
   $display("[FAIL] %0t ns: %s got %h want %h", $time, m, a, e); end end
module line_exposure_timing_control_tb_top;
   logic        sys_clk = 1'b0;
   logic        rst     = 1'b1;
   logic        cyc_i   = 1'b0;
   logic        stb_i   = 1'b0;
   logic        we_i    = 1'b0;
   logic [7:0]  adr_i   = 8'h00;
   logic [3:0]  sel_i   = 4'hf;
   logic [31:0] dat_i   = 32'h0;
   logic [31:0] q;                       // Last read data.
   logic [15:0] ecMask  = 16'h0174;      // Modes that keep exposure control on.
   wire         ack_o, externalLineTrigger, pixelResetInput;
   wire         exposureOn, chargeClearPulse, readoutStart, exposureControlOn;
   wire  [31:0] dat_o;
   int          miscompares = 0;
   int          checked     = 0;
   int          cycles      = 0;
   int          c;

   always #25 sys_clk = ~sys_clk;

   // The run needs about 18000 cycles; a hang is cut off well beyond that.
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         $display("[FAIL] %0t ns: run timed out", $time);
         miscompares = miscompares + 1;
         finish_test();
      end
   end

   lxt_line_exposure_timing i_dut (.sys_clk, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o,
      .dat_o, .externalLineTrigger, .pixelResetInput, .exposureOn, .chargeClearPulse, .readoutStart,
      .exposureControlOn);
   lxt_trig_src i_src (.sys_clk, .externalLineTrigger, .pixelResetInput);

   // One classic cycle; the request stands until ack is sampled, so slow answers are safe.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {1'b1, 1'b1, w, a, d};
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack_o !== 1'b1 && n < 100);
      q = dat_o;
      {cyc_i, stb_i, we_i} <= 3'b000;
      if (n >= 100) miscompares++;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `TB_CHK(q, e, "register read")
   endtask

   // Reads the sticky error flags, compares them, then clears them.
   task automatic errc(input logic [2:0] e);
      wb(1'b0, 8'h10, 32'h0);
      `TB_CHK(q[2:0], e, "error flags")
      wb(1'b1, 8'h10, 32'h7);
   endtask

   // Cycles between two readout pulses.
   task automatic gap(output int g);
      int n;
      n = 0;
      while (readoutStart !== 1'b1 && n < 9000) begin
         @(posedge sys_clk);
         n++;
      end
      g = 0;
      do begin
         @(posedge sys_clk);
         g++;
      end while (readoutStart !== 1'b1 && g < 9000);
   endtask

   // Length of the next exposure in cycles.
   task automatic width(output int w);
      int n;
      n = 0;
      while (exposureOn !== 1'b1 && n < 9000) begin
         @(posedge sys_clk);
         n++;
      end
      w = 0;
      while (exposureOn === 1'b1 && w < 9000) begin
         @(posedge sys_clk);
         w++;
      end
   endtask

   // Microsecond ticks come from a free divider, so timing may slip by one tick.
   task automatic near(input int v, input int e);
      `TB_CHK(v >= e - 20 && v <= e + 20, 1'b1, "timing window")
   endtask

   task automatic done(input string s);
      $display("test done: %s", s);
   endtask

   task automatic finish_test();
      $display("checked %0d, miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      rdc(8'h00, 32'h7);
      rdc(8'h04, 32'h2710);
      rdc(8'h18, 32'h64);
      rdc(8'h14, 32'h5d);
      wb(1'b0, 8'h10, 32'h0);
      `TB_CHK(q[2:0], 3'h0, "error flags at reset")
      `TB_CHK(q[3], 1'b0, "control flag at reset")
      gap(c);
      `TB_CHK(c, 32'h7d0, "mode 7 line")
      width(c);
      near(c, 32'h744);
      done("reset and mode 7");
      wb(1'b1, 8'h04, 32'h12b);
      errc(3'h1);
      rdc(8'h04, 32'h2710);
      wb(1'b1, 8'h04, 32'h8ca1);
      errc(3'h1);
      wb(1'b1, 8'h0c, 32'h4);
      wb(1'b1, 8'h04, 32'h8ca1);
      errc(3'h0);
      rdc(8'h18, 32'h1b);
      wb(1'b1, 8'h0c, 32'h0);
      wb(1'b1, 8'h04, 32'h4e20);
      rdc(8'h14, 32'h2b);
      wb(1'b1, 8'h08, 32'h28);
      errc(3'h2);
      wb(1'b1, 8'h00, 32'h9);
      errc(3'h4);
      rdc(8'h00, 32'h7);
      done("rate, exposure and mode refusals");
      for (int m = 2; m <= 8; m++) begin
         wb(1'b1, 8'h00, 32'(m));
         rdc(8'h00, 32'(m));
         wb(1'b0, 8'h10, 32'h0);
         `TB_CHK(q[3], ecMask[m], "control flag")
      end
      wb(1'b1, 8'h08, 32'h64);
      rdc(8'h18, 32'h69);
      gap(c);
      `TB_CHK(c, 32'h834, "mode 8 line")
      done("mode table and mode 8");
      wb(1'b1, 8'h00, 32'h2);
      wb(1'b1, 8'h04, 32'h2710);
      wb(1'b1, 8'h08, 32'h5a);
      wb(1'b1, 8'h04, 32'h4e20);
      rdc(8'h08, 32'h2b);
      wb(1'b1, 8'h08, 32'hc8);
      rdc(8'h18, 32'hcd);
      wb(1'b1, 8'h08, 32'h2);
      wb(1'b1, 8'h08, 32'hce5);
      errc(3'h2);
      rdc(8'h08, 32'hc8);
      done("mode 2 trade-offs");
      for (int m = 3; m <= 5; m++) begin
         wb(1'b1, 8'h00, 32'(m));
         fork
            i_src.lines(m == 4 ? 300 : 100, m == 4 ? 299 : 499, 3, m == 5 ? 200 : 0);
            gap(c);
         join
         `TB_CHK(c, 32'h258, "external line period")
      end
      done("external modes 3 to 5");
      wb(1'b1, 8'h00, 32'h6);
      wb(1'b1, 8'h08, 32'h2c);
      errc(3'h2);
      wb(1'b1, 8'h08, 32'ha);
      fork
         i_src.lines(50, 549, 3, 0);
         width(c);
      join
      near(c, 32'hc8);
      done("mode 6 fixed exposure");
      finish_test();
   end
endmodule // line_exposure_timing_control_tb_top

// [test/lxt_trig_src.sv]
// Model of the external trigger source that drives the line trigger and the pixel reset input.
// Assumes sys_clk is the controller's clock; every change is made just after a rising edge.
`timescale 1ns/1ps
module lxt_trig_src (
   input  wire logic sys_clk,
   output logic      externalLineTrigger,
   output logic      pixelResetInput
);
   // Both lines rest low so that the controller sees no edge outside a burst.
   initial begin
      externalLineTrigger = 1'b0;
      pixelResetInput     = 1'b0;
   end

   // Sends n trigger pulses of hi cycles high and lo + 1 cycles low; the period is hi + lo + 1.
   // A positive prstAt also raises the pixel reset input for 10 cycles that far into the low part.
   task automatic lines(input int hi, input int lo, input int n, input int prstAt);
      for (int k = 0; k < n; k++) begin
         @(posedge sys_clk);
         externalLineTrigger <= 1'b1;
         repeat (hi) @(posedge sys_clk);
         externalLineTrigger <= 1'b0;
         for (int c = 0; c < lo; c++) begin
            @(posedge sys_clk);
            pixelResetInput <= (prstAt > 0 && c >= prstAt && c < prstAt + 10);
         end
      end
   endtask
endmodule // lxt_trig_src
